// ===== verilog/cma_cfg.svh
// Constants for the configuration mode register access unit.
// Assumes inclusion by bare name from the package and both ends.
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
`define CMA_PORT_INDEX 1'b0
`define CMA_PORT_DATA 1'b1
`define CMA_KEY_ENTER 8'h55
`define CMA_KEY_EXIT 8'haa
`define CMA_NUM_REGS 32
`define CMA_IDX_POWER 5'h00
`define CMA_IDX_LOCK 5'h01
`define CMA_IDX_MODE 5'h03
`define CMA_IDX_DENS 5'h05
`define CMA_IDX_TYPES 5'h06
`define CMA_IDX_BOOT 5'h07
`define CMA_IDX_RATE 5'h0b
`define CMA_IDX_ID 5'h0d
`define CMA_IDX_REV 5'h0e
`define CMA_IDX_TEST_A 5'h0f
`define CMA_IDX_TEST_C 5'h11
`define CMA_IDX_DTYPE 5'h1f
`define CMA_RST_POWER 8'h28
`define CMA_RST_LOCK 8'h90
`define CMA_RST_MODE 8'h70
`define CMA_RST_TYPES 8'hff
`define CMA_RST_ZERO 8'h00
// Writable bit masks; other bits read as their fixed values
`define CMA_MASK_POWER 8'hac
`define CMA_MASK_LOCK 8'h80
`define CMA_MASK_MODE 8'hf2
`define CMA_MASK_DENS 8'h7c
`define CMA_MASK_ALL 8'hff
`define CMA_LOCK_BIT 7
`endif

// ===== verilog/cma_pkg.sv
// Types shared by both ends of the configuration access unit.
// Assumes the constants header is on the include path.
`include "cma_cfg.svh"
package cma_pkg;
   typedef logic [7:0] cma_byte_t;
   typedef logic [4:0] cma_index_t;
   typedef enum logic [1:0] {
      CMA_LOCKED = 2'b00,
      CMA_KEY_ONE = 2'b01,
      CMA_OPEN = 2'b10
   } cma_mode_e;
   typedef enum logic [1:0] {
      CMA_H_IDLE = 2'b00,
      CMA_H_BUSY = 2'b01
   } cma_host_e;
endpackage : cma_pkg

// ===== verilog/cma_if.sv
// Port-level carrier between host and configuration device.
// Assumes one shared clock; data bus is split into in, out, enable.
`timescale 1ns/1ps
interface cma_if;
   logic chip_select_n;
   logic addr;
   logic wr_strobe;
   logic rd_strobe;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rdata_oe;
   modport device (
      input chip_select_n,
      input addr,
      input wr_strobe,
      input rd_strobe,
      input wdata,
      output rdata,
      output rdata_oe
   );
   modport host (
      output chip_select_n,
      output addr,
      output wr_strobe,
      output rd_strobe,
      output wdata,
      input rdata,
      input rdata_oe
   );
endinterface : cma_if

// ===== verilog/cma_device.sv
// Device end: unlock key, index select and 32 configuration registers.
// Assumes synchronous one-cycle strobes from the host end; por is the
// power-up reset, rst the ordinary hardware reset.
//
// Overview of operation
// - Two successive 55h index writes unlock mode
// - Any other write between keys cancels unlock
// - Host masks interrupts during the key pair
// - Index write in mode loads select register
// - Data port reaches register named by select
// - Writing AAh to index exits the mode
// - Select register usable only inside the mode
// - Host loads select before data accesses
// - Select register distinct from data registers
// - Register 07h holds power, media, boot; resets 00h
// - Respond only at offsets 0,1 with chip select; a write strobe without chip select still cancels a pending first key
// - Registers reset only at power-up, not rst
// - Cleared lock bit blocks access until power-up
`timescale 1ns/1ps
`include "cma_cfg.svh"
module cma_device
   import cma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic por,
   cma_if.device bus,
   output logic in_config_mode,
   output logic [7:0] power_osc_control,
   output logic [7:0] power_media_boot_select,
   output logic [7:0] floppy_drive_types,
   output logic [4:0] config_index_select
);
   // Arbitrary identity values
   localparam logic [7:0] DEVICE_ID = 8'h5a;
   localparam logic [7:0] DEVICE_REV = 8'h01;

   cma_mode_e mode_reg;
   cma_index_t sel_reg;
   cma_byte_t cfg_reg [`CMA_NUM_REGS];
   cma_byte_t rdata_reg;
   logic oe_reg;
   logic sel_idx;
   logic idx_wr;
   logic dat_wr;
   logic dat_rd;
   logic access_ok;

   // Decode of the two ports under chip select
   assign sel_idx = !bus.chip_select_n;
   assign idx_wr = sel_idx && bus.wr_strobe && bus.addr == `CMA_PORT_INDEX;
   assign dat_wr = sel_idx && bus.wr_strobe && bus.addr == `CMA_PORT_DATA;
   assign dat_rd = sel_idx && bus.rd_strobe && bus.addr == `CMA_PORT_DATA;
   assign access_ok = mode_reg == CMA_OPEN &&
      cfg_reg[`CMA_IDX_LOCK][`CMA_LOCK_BIT];

   // Unlock, open and exit sequence
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mode_reg <= CMA_LOCKED;
      else
      begin
         case (mode_reg)
            CMA_LOCKED:
            begin
               if (idx_wr && bus.wdata == `CMA_KEY_ENTER)
                  mode_reg <= CMA_KEY_ONE;
            end
            CMA_KEY_ONE:
            begin
               if (idx_wr && bus.wdata == `CMA_KEY_ENTER)
                  mode_reg <= CMA_OPEN;
               else if (bus.wr_strobe)
                  mode_reg <= CMA_LOCKED;
            end
            CMA_OPEN:
            begin
               if (idx_wr && bus.wdata == `CMA_KEY_EXIT)
                  mode_reg <= CMA_LOCKED;
            end
            default: mode_reg <= CMA_LOCKED;
         endcase
      end
   end

   // Select register, written only inside the mode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sel_reg <= 5'h00;
      else if (idx_wr && mode_reg == CMA_OPEN &&
               bus.wdata != `CMA_KEY_EXIT)
         sel_reg <= bus.wdata[4:0];
   end

   // Power-up value of each register, by index
   localparam cma_byte_t RST_TABLE [`CMA_NUM_REGS] = '{
      // 00h to 07h
      `CMA_RST_POWER,
      `CMA_RST_LOCK,
      `CMA_RST_ZERO,
      `CMA_RST_MODE,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_TYPES,
      `CMA_RST_ZERO,
      // 08h to 0fh
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      DEVICE_ID,
      DEVICE_REV,
      `CMA_RST_ZERO,
      // 10h to 17h
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      // 18h to 1fh
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO
   };

   // Bits a data-port write may change, by index; the rest hold
   localparam cma_byte_t MASK_TABLE [`CMA_NUM_REGS] = '{
      // 00h to 07h
      `CMA_MASK_POWER,
      `CMA_MASK_LOCK,
      `CMA_RST_ZERO,
      `CMA_MASK_MODE,
      `CMA_RST_ZERO,
      `CMA_MASK_DENS,
      `CMA_MASK_ALL,
      `CMA_MASK_ALL,
      // 08h to 0fh
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_MASK_ALL,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_MASK_ALL,
      // 10h to 17h
      `CMA_MASK_ALL,
      `CMA_MASK_ALL,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      // 18h to 1fh
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_RST_ZERO,
      `CMA_MASK_ALL
   };

   // Configuration registers: power-up reset only, masked writes
   genvar gi;
   generate
      for (gi = 0; gi < `CMA_NUM_REGS; gi++)
      begin : g_cfg
         localparam logic [4:0] IDX = 5'(gi);
         localparam cma_byte_t RST_VAL = RST_TABLE[gi];
         localparam cma_byte_t MASK = MASK_TABLE[gi];
         always_ff @(posedge clk or posedge por)
         begin
            if (por)
               cfg_reg[gi] <= RST_VAL;
            else if (dat_wr && access_ok && sel_reg == IDX)
               cfg_reg[gi] <= (cfg_reg[gi] & ~MASK) |
                  (bus.wdata & MASK);
         end
      end
   endgenerate

   // Read data from the selected register, one cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_reg <= 8'h00;
         oe_reg <= 1'b0;
      end
      else
      begin
         oe_reg <= dat_rd && access_ok;
         if (dat_rd && access_ok)
            rdata_reg <= cfg_reg[sel_reg];
      end
   end

   assign bus.rdata = rdata_reg;
   assign bus.rdata_oe = oe_reg;
   assign in_config_mode = mode_reg == CMA_OPEN;
   assign power_osc_control = cfg_reg[`CMA_IDX_POWER];
   assign power_media_boot_select = cfg_reg[`CMA_IDX_BOOT];
   assign floppy_drive_types = cfg_reg[`CMA_IDX_TYPES];
   assign config_index_select = sel_reg;
endmodule : cma_device

// ===== verilog/cma_host.sv
// Host end: turns user write/read requests into port strobes.
// Assumes a single clock shared with the device end.
`timescale 1ns/1ps
`include "cma_cfg.svh"
module cma_host
   import cma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   cma_if.host bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_addr,
   input wire logic [7:0] req_wdata,
   output logic req_ready,
   output logic resp_valid,
   output logic [7:0] resp_rdata
);
   cma_host_e state_reg;
   logic wr_reg;
   logic rd_reg;
   logic addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic resp_reg;

   // Requests accepted only while idle; the user keeps the key pair
   // back to back and loads the index before data access
   assign req_ready = state_reg == CMA_H_IDLE;

   // Strobe generation, one cycle per access
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= CMA_H_IDLE;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         addr_reg <= 1'b0;
         wdata_reg <= 8'h00;
      end
      else
      begin
         case (state_reg)
            CMA_H_IDLE:
            begin
               if (req_valid)
               begin
                  state_reg <= CMA_H_BUSY;
                  wr_reg <= req_write;
                  rd_reg <= !req_write;
                  addr_reg <= req_addr;
                  wdata_reg <= req_wdata;
               end
            end
            CMA_H_BUSY:
            begin
               state_reg <= CMA_H_IDLE;
               wr_reg <= 1'b0;
               rd_reg <= 1'b0;
            end
            default: state_reg <= CMA_H_IDLE;
         endcase
      end
   end

   // Capture read data on the answer enable, one cycle after the read strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         resp_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         resp_reg <= bus.rdata_oe;
         if (bus.rdata_oe)
            rdata_reg <= bus.rdata;
      end
   end

   assign bus.chip_select_n = !(wr_reg || rd_reg);
   assign bus.addr = addr_reg;
   assign bus.wr_strobe = wr_reg;
   assign bus.rd_strobe = rd_reg;
   assign bus.wdata = wdata_reg;
   assign resp_valid = resp_reg;
   assign resp_rdata = rdata_reg;
endmodule : cma_host

// ===== test/cma_assertions.sv
// Checker for the port bus between the host and device ends.
// Assumes one clock; instantiated beside the joining interface.
`timescale 1ns/1ps
module cma_assertions
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic addr,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe
);
   logic last_key_reg;
   logic open_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Remembers whether the last write was an index key
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         last_key_reg <= 1'b0;
      else if (wr_strobe)
         last_key_reg <= !addr && wdata == 8'h55;
   end
   // Follows the open or closed state of the mode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         open_reg <= 1'b0;
      else if (wr_strobe && !addr && wdata == 8'haa)
         open_reg <= 1'b0;
      else if (wr_strobe && !addr && wdata == 8'h55 && last_key_reg)
         open_reg <= 1'b1;
   end
   sequence s_data_read;
      rd_strobe && addr && !chip_select_n;
   endsequence
   chk_oe_single: assert property (rdata_oe |=> !rdata_oe)
      else $error("read answer longer than one cycle");
   chk_oe_cause: assert property (rdata_oe |-> $past(rd_strobe)
      && $past(addr) && !$past(chip_select_n))
      else $error("read answer without a data read");
   chk_index_silent: assert property (rd_strobe && !addr |=> !rdata_oe)
      else $error("index port answered a read");
   chk_closed_quiet: assert property (s_data_read ##0 !open_reg
      |=> !rdata_oe)
      else $error("data read answered outside the mode");
   chk_wr_pulse: assert property (wr_strobe |=> !wr_strobe)
      else $error("write strobe longer than one cycle");
   chk_strobe_excl: assert property (!(wr_strobe && rd_strobe))
      else $error("read and write strobe together");
   chk_strobe_cs: assert property (wr_strobe || rd_strobe
      |-> !chip_select_n)
      else $error("strobe without chip select");
   chk_rdata_hold: assert property (!rdata_oe |-> $stable(rdata))
      else $error("read data changed without a read");
endmodule : cma_assertions

// ===== test/test_config_mode_register_access.sv
// Testbench joining host and device ends across the port bus.
// Assumes design files and the checker are compiled before it.
`timescale 1ns/1ps
module test_config_mode_register_access
   import cma_pkg::*;
;
   logic clk, rst, por, req_valid, req_write, req_addr, req_ready;
   logic resp_valid, in_config_mode;
   cma_byte_t req_wdata, resp_rdata, pwr, boot, types;
   cma_index_t sel;
   int n_fail, n_checks;
   cma_if cma_if_inst();
   cma_host cma_host_inst(.clk(clk), .rst(rst), .bus(cma_if_inst.host),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata));
   cma_device cma_device_inst(.clk(clk), .rst(rst), .por(por),
      .bus(cma_if_inst.device), .in_config_mode(in_config_mode),
      .power_osc_control(pwr), .power_media_boot_select(boot),
      .floppy_drive_types(types), .config_index_select(sel));
   cma_assertions cma_assertions_inst(.clk(clk), .rst(rst),
      .chip_select_n(cma_if_inst.chip_select_n), .addr(cma_if_inst.addr),
      .wr_strobe(cma_if_inst.wr_strobe), .rd_strobe(cma_if_inst.rd_strobe),
      .wdata(cma_if_inst.wdata), .rdata(cma_if_inst.rdata),
      .rdata_oe(cma_if_inst.rdata_oe));
   // Clock of 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task cmp8(input cma_byte_t got, input cma_byte_t exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp8
   // One host request, then idle until its answer has settled
   task access(input logic wr, input logic a, input cma_byte_t d);
      int k;
      for (k = 0; k < 8 && req_ready !== 1'b1; k++)
         @(posedge clk) #1;
      if (req_ready !== 1'b1)
      begin
         n_fail++;
         complete_run();
      end
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(posedge clk) #1;
      req_valid = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : access
   task keys;
      access(1'b1, 1'b0, 8'h55);
      access(1'b1, 1'b0, 8'h55);
   endtask : keys
   task t_defaults;
      cmp8(pwr, 8'h28);
      cmp8(types, 8'hff);
      cmp8(boot, 8'h00);
      cmp8({7'h0, in_config_mode}, 8'h00);
      cmp8({7'h0, req_ready}, 8'h01);
      $display("defaults done");
   endtask : t_defaults
   task t_unlock;
      access(1'b1, 1'b0, 8'h55);
      access(1'b1, 1'b1, 8'h00);
      access(1'b1, 1'b0, 8'h55);
      cmp8({7'h0, in_config_mode}, 8'h00);
      access(1'b1, 1'b0, 8'h55);
      cmp8({7'h0, in_config_mode}, 8'h01);
      $display("unlock done");
   endtask : t_unlock
   task t_select;
      access(1'b1, 1'b0, 8'h07);
      cmp8({3'h0, sel}, 8'h07);
      access(1'b1, 1'b1, 8'ha5);
      cmp8(boot, 8'ha5);
      access(1'b0, 1'b1, 8'h00);
      cmp8({7'h0, resp_valid}, 8'h01);
      cmp8(resp_rdata, 8'ha5);
      access(1'b1, 1'b0, 8'h00);
      access(1'b1, 1'b1, 8'hff);
      cmp8(pwr, 8'hac);
      access(1'b0, 1'b0, 8'h00);
      $display("select done");
   endtask : t_select
   task t_reset;
      rst = 1'b1;
      repeat (2) @(posedge clk) #1;
      rst = 1'b0;
      cmp8({7'h0, in_config_mode}, 8'h00);
      cmp8(boot, 8'ha5);
      cmp8(pwr, 8'hac);
      $display("reset done");
   endtask : t_reset
   task t_exit;
      keys();
      access(1'b1, 1'b0, 8'haa);
      cmp8({7'h0, in_config_mode}, 8'h00);
      access(1'b1, 1'b0, 8'h03);
      cmp8({3'h0, sel}, 8'h00);
      access(1'b1, 1'b1, 8'h3c);
      access(1'b0, 1'b1, 8'h00);
      cmp8({7'h0, resp_valid}, 8'h00);
      cmp8(pwr, 8'hac);
      $display("exit done");
   endtask : t_exit
   task t_lock;
      keys();
      access(1'b1, 1'b0, 8'h01);
      access(1'b1, 1'b1, 8'h00);
      access(1'b1, 1'b0, 8'h07);
      access(1'b1, 1'b1, 8'h11);
      cmp8(boot, 8'ha5);
      access(1'b0, 1'b1, 8'h00);
      cmp8({7'h0, resp_valid}, 8'h00);
      access(1'b1, 1'b0, 8'haa);
      por = 1'b1;
      repeat (2) @(posedge clk) #1;
      por = 1'b0;
      cmp8(boot, 8'h00);
      keys();
      access(1'b1, 1'b0, 8'h01);
      access(1'b0, 1'b1, 8'h00);
      cmp8(resp_rdata, 8'h90);
      $display("lock done");
   endtask : t_lock
   // Reset for 12 cycles, then run every scenario
   initial
   begin
      {req_valid, req_write, req_addr, req_wdata} = '0;
      n_fail = 0;
      n_checks = 0;
      rst = 1'b1;
      por = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      por = 1'b0;
      t_defaults();
      t_unlock();
      t_select();
      t_reset();
      t_exit();
      t_lock();
      complete_run();
   end
endmodule : test_config_mode_register_access
